/* hw/tcu_regs.vh */
// register offsets, field positions and reset values of the timer unit
// assumes a 32-bit avalon-mm slave with word addresses in bytes
`ifndef TCU_REGS_VH
`define TCU_REGS_VH
// ---------------------------------------------------------------
// offsets
// ---------------------------------------------------------------
`define TCU_OFS_CTRL 4'h0
`define TCU_OFS_COUNT 4'h4
`define TCU_OFS_CMP 4'h8
`define TCU_OFS_FLAG 4'hc
// ---------------------------------------------------------------
// control fields
// ---------------------------------------------------------------
`define TCU_CS_LSB 0
`define TCU_WGM_LSB 3
`define TCU_COM_LSB 5
`define TCU_FOC_BIT 7
// ---------------------------------------------------------------
// flag / mask / global enable fields (0x0c)
// ---------------------------------------------------------------
`define TCU_FLG_OVF_BIT 0
`define TCU_FLG_CMP_BIT 1
`define TCU_MSK_OVF_BIT 8
`define TCU_MSK_CMP_BIT 9
`define TCU_GIE_BIT 16
// ---------------------------------------------------------------
// reset values and count limits
// ---------------------------------------------------------------
`define TCU_RST_CTRL 8'h00
`define TCU_RST_BYTE 8'h00
`define TCU_MAX_VAL 8'hff
`define TCU_BOT_VAL 8'h00
`endif

/* hw/tcu_tick_sel.v */
// clock select and prescaler producing the one-cycle timer tick
// assumes ext pin is asynchronous; synchronised here
`timescale 1ns/1ps
module tcu_tick_sel #(
  parameter PRE_W = 10
) (
  input wire clk_sys_in,
  input wire sys_rst_in,
  input wire [2:0] clock_select_in,
  input wire ext_count_input_in,
  output wire timer_tick_out
);
  reg [PRE_W-1:0] pre_ff;
  reg ext_s1_ff;
  reg ext_s2_ff;
  reg ext_d_ff;
  reg tick;
  // ---------------------------------------------------------------
  // prescaler and pin synchroniser
  // ---------------------------------------------------------------
  always @(posedge clk_sys_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      pre_ff <= {PRE_W{1'b0}};
      ext_s1_ff <= 1'b0;
      ext_s2_ff <= 1'b0;
      ext_d_ff <= 1'b0;
    end
    else
    begin
      pre_ff <= pre_ff + {{(PRE_W-1){1'b0}}, 1'b1};
      ext_s1_ff <= ext_count_input_in;
      ext_s2_ff <= ext_s1_ff;
      ext_d_ff <= ext_s2_ff;
    end
  end
  // ---------------------------------------------------------------
  // source and edge selection
  // ---------------------------------------------------------------
  always @*
  begin
    case (clock_select_in)
      3'h0: tick = 1'b0; // stopped
      3'h1: tick = 1'b1;
      3'h2: tick = (pre_ff[2:0] == 3'h7);
      3'h3: tick = (pre_ff[5:0] == 6'h3f);
      3'h4: tick = (pre_ff[7:0] == 8'hff);
      3'h5: tick = (pre_ff[9:0] == 10'h3ff);
      3'h6: tick = ext_d_ff & ~ext_s2_ff; // falling edge
      3'h7: tick = ~ext_d_ff & ext_s2_ff; // rising edge
      default: tick = 1'b0;
    endcase
  end
  assign timer_tick_out = tick;
endmodule

/* hw/tcu_timer.v */
// 8-bit timer/counter with one compare channel, avalon-mm slave
// assumes a single 250 mhz clock; ext pin and irq ack from outside
//
// Function
// - count and compare are cpu-accessible 8-bit registers
// - select prescaled clock or ext pin edge
// - clock select zero stops the counter
// - tick clears, increments or decrements counter
// - counter readable and writable any time
// - cpu write beats count or clear
// - waveform mode sets direction and clear point
// - bottom at 0x00, max at 0xff
// - top is max or compare value
// - top feeds waveform generator; bottom is only an output
// - overflow flag per mode, may interrupt
// - comparator matches on equality continuously
// - match sets compare flag next tick
// - compare irq needs enable and global enable
// - flag cleared by service or writing one
// - shared mask and flag registers
// - output driven from match, mode, action
// - pwm double buffers compare, load at top
// - cpu reaches buffer in pwm, else active
// - force strobe acts as match outside pwm
// - forced match sets no flag, no reload
// - counter write blocks next tick's match
// - normal mode counts up, overflow at zero
// - action zero leaves output untouched
//
// Local design decisions: the Avalon-MM register port and the register addresses.
`timescale 1ns/1ps
`include "tcu_regs.vh"
module tcu_timer #(
  parameter PRE_W = 10
) (
  input wire clk_sys_in,
  input wire sys_rst_in,
  input wire [3:0] avs_address_in,
  input wire avs_read_in,
  input wire avs_write_in,
  input wire [31:0] avs_writedata_in,
  input wire [3:0] avs_byteenable_in,
  output wire avs_waitrequest_out,
  output reg [31:0] avs_readdata_out,
  input wire ext_count_input_in,
  input wire ovf_irq_ack_in,
  input wire cmp_irq_ack_in,
  output wire ovf_irq_out,
  output wire cmp_irq_out,
  output wire compare_output_out,
  output wire top_out,
  output wire bottom_out
);
  localparam WGM_NORMAL = 2'h0;
  localparam WGM_PCPWM = 2'h1;
  localparam WGM_CTC = 2'h2;
  localparam WGM_FPWM = 2'h3;
  localparam ACC_IDLE = 1'b0;
  localparam ACC_DONE = 1'b1;

  reg acc_ff;
  reg [6:0] ctrl_ff;
  reg [7:0] count_value_ff;
  reg [7:0] compare_value_ff;
  reg [7:0] cmp_buf_ff;
  reg down_ff;
  reg ovf_flag_ff;
  reg cmp_flag_ff;
  reg ovf_msk_ff;
  reg cmp_msk_ff;
  reg gie_ff;
  reg block_ff;
  reg match_d_ff;
  reg oc_ff;
  reg [7:0] nxt_count;
  reg nxt_down;
  reg nxt_oc;
  reg set_ovf;
  reg load_buf;
  wire tick;
  wire [2:0] clock_select;
  wire [1:0] waveform_mode;
  wire [1:0] compare_output_action;
  wire pwm;
  wire [7:0] top_val;
  wire match;
  wire wr_acc;
  wire rd_acc;
  wire wr_ctrl;
  wire wr_cnt;
  wire wr_cmp;
  wire wr_flg;
  wire force_cmp;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function is_pwm;
    input [1:0] m;
    begin
      is_pwm = (m == WGM_PCPWM) || (m == WGM_FPWM);
    end
  endfunction

  function oc_action;
    input [1:0] act;
    input cur;
    input up;
    begin
      case (act)
        2'h0: oc_action = cur; // no action
        2'h1: oc_action = ~cur;
        2'h2: oc_action = ~up;
        2'h3: oc_action = up;
        default: oc_action = cur;
      endcase
    end
  endfunction

  assign clock_select = ctrl_ff[`TCU_CS_LSB +: 3];
  assign waveform_mode = ctrl_ff[`TCU_WGM_LSB +: 2];
  assign compare_output_action = ctrl_ff[`TCU_COM_LSB +: 2];
  assign pwm = is_pwm(waveform_mode);

  // ---------------------------------------------------------------
  // clock select
  // ---------------------------------------------------------------
  tcu_tick_sel #(
    .PRE_W(PRE_W)
  ) u_tick (
    .clk_sys_in(clk_sys_in),
    .sys_rst_in(sys_rst_in),
    .clock_select_in(clock_select),
    .ext_count_input_in(ext_count_input_in),
    .timer_tick_out(tick)
  );

  // ---------------------------------------------------------------
  // bus slave: one wait cycle per access
  // ---------------------------------------------------------------
  assign avs_waitrequest_out = (avs_read_in | avs_write_in) &
    (acc_ff == ACC_IDLE);
  assign wr_acc = avs_write_in & (acc_ff == ACC_DONE);
  assign rd_acc = avs_read_in & (acc_ff == ACC_DONE);
  assign wr_ctrl = wr_acc & (avs_address_in == `TCU_OFS_CTRL) &
    avs_byteenable_in[0];
  assign wr_cnt = wr_acc & (avs_address_in == `TCU_OFS_COUNT) &
    avs_byteenable_in[0];
  assign wr_cmp = wr_acc & (avs_address_in == `TCU_OFS_CMP) &
    avs_byteenable_in[0];
  assign wr_flg = wr_acc & (avs_address_in == `TCU_OFS_FLAG);
  // strobe ignored in pwm modes
  assign force_cmp = wr_ctrl & avs_writedata_in[`TCU_FOC_BIT] &
    ~is_pwm(avs_writedata_in[`TCU_WGM_LSB +: 2]);

  always @(posedge clk_sys_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
      acc_ff <= ACC_IDLE;
    else if (acc_ff == ACC_DONE)
      acc_ff <= ACC_IDLE;
    else if (avs_read_in | avs_write_in)
      acc_ff <= ACC_DONE;
  end

  always @(posedge clk_sys_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
      avs_readdata_out <= 32'h0000_0000;
    else if (avs_read_in & (acc_ff == ACC_IDLE))
    begin
      case (avs_address_in)
        `TCU_OFS_CTRL: avs_readdata_out <= {25'h0, ctrl_ff};
        `TCU_OFS_COUNT: avs_readdata_out <= {24'h0, count_value_ff};
        // pwm reads see the buffer
        `TCU_OFS_CMP: avs_readdata_out <= {24'h0,
          (pwm ? cmp_buf_ff : compare_value_ff)};
        `TCU_OFS_FLAG: avs_readdata_out <= {15'h0, gie_ff, 6'h0,
          cmp_msk_ff, ovf_msk_ff, 6'h0, cmp_flag_ff,
          ovf_flag_ff};
        default: avs_readdata_out <= 32'h0000_0000;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // counter unit
  // ---------------------------------------------------------------
  assign top_val = (waveform_mode == WGM_CTC) ? compare_value_ff :
    `TCU_MAX_VAL;
  assign match = (count_value_ff == compare_value_ff);
  assign top_out = (count_value_ff == top_val);
  assign bottom_out = (count_value_ff == `TCU_BOT_VAL);

  always @*
  begin
    nxt_count = count_value_ff;
    nxt_down = down_ff;
    set_ovf = 1'b0;
    load_buf = 1'b0;
    case (waveform_mode)
      WGM_NORMAL:
      begin
        nxt_count = count_value_ff + 8'h01; // wraps ff->00
        set_ovf = (count_value_ff == `TCU_MAX_VAL);
      end
      WGM_CTC:
      begin
        if (match)
          nxt_count = `TCU_BOT_VAL; // clear at top
        else
          nxt_count = count_value_ff + 8'h01;
        set_ovf = (count_value_ff == `TCU_MAX_VAL);
      end
      WGM_FPWM:
      begin
        nxt_count = count_value_ff + 8'h01;
        set_ovf = (count_value_ff == `TCU_MAX_VAL);
        load_buf = (count_value_ff == `TCU_MAX_VAL); // at top
      end
      WGM_PCPWM:
      begin
        // dual slope; buffer loads at top, overflow at bottom
        if (down_ff)
        begin
          nxt_count = count_value_ff - 8'h01;
          if (count_value_ff == 8'h01)
            nxt_down = 1'b0;
        end
        else
        begin
          nxt_count = count_value_ff + 8'h01;
          if (count_value_ff == 8'hfe)
            nxt_down = 1'b1;
        end
        set_ovf = down_ff & (count_value_ff == 8'h01);
        load_buf = (count_value_ff == `TCU_MAX_VAL);
      end
      default: nxt_count = count_value_ff;
    endcase
  end

  always @(posedge clk_sys_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      count_value_ff <= `TCU_RST_BYTE;
      down_ff <= 1'b0;
      block_ff <= 1'b0;
    end
    else
    begin
      if (wr_cnt)
      begin
        count_value_ff <= avs_writedata_in[7:0]; // priority
        down_ff <= down_ff;
      end
      else if (tick)
      begin
        count_value_ff <= nxt_count;
        down_ff <= nxt_down;
      end
      if (wr_cnt)
        block_ff <= 1'b1; // held until a tick, even when stopped
      else if (tick)
        block_ff <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // control, compare value, buffer
  // ---------------------------------------------------------------
  always @(posedge clk_sys_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      ctrl_ff <= 7'h00;
      compare_value_ff <= `TCU_RST_BYTE;
      cmp_buf_ff <= `TCU_RST_BYTE;
      ovf_msk_ff <= 1'b0;
      cmp_msk_ff <= 1'b0;
      gie_ff <= 1'b0;
    end
    else
    begin
      if (wr_ctrl)
        ctrl_ff <= avs_writedata_in[6:0];
      if (wr_cmp & pwm)
        cmp_buf_ff <= avs_writedata_in[7:0];
      if (wr_cmp & ~pwm)
        compare_value_ff <= avs_writedata_in[7:0]; // direct
      else if (pwm & tick & load_buf)
        compare_value_ff <= cmp_buf_ff;
      if (~pwm & ~wr_cmp)
        cmp_buf_ff <= compare_value_ff;
      if (wr_flg & avs_byteenable_in[1])
      begin
        ovf_msk_ff <= avs_writedata_in[`TCU_MSK_OVF_BIT];
        cmp_msk_ff <= avs_writedata_in[`TCU_MSK_CMP_BIT];
      end
      if (wr_flg & avs_byteenable_in[2])
        gie_ff <= avs_writedata_in[`TCU_GIE_BIT];
    end
  end

  // ---------------------------------------------------------------
  // flags: set wins over clear
  // ---------------------------------------------------------------
  always @(posedge clk_sys_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      ovf_flag_ff <= 1'b0;
      cmp_flag_ff <= 1'b0;
      match_d_ff <= 1'b0;
    end
    else
    begin
      if (tick)
        match_d_ff <= match & ~block_ff & ~wr_cnt;
      if (tick & set_ovf & ~wr_cnt)
        ovf_flag_ff <= 1'b1;
      else if (ovf_irq_ack_in | (wr_flg & avs_byteenable_in[0] &
        avs_writedata_in[`TCU_FLG_OVF_BIT]))
        ovf_flag_ff <= 1'b0;
      // flag rises on the tick after the match
      if (tick & match_d_ff)
        cmp_flag_ff <= 1'b1;
      else if (cmp_irq_ack_in | (wr_flg & avs_byteenable_in[0] &
        avs_writedata_in[`TCU_FLG_CMP_BIT]))
        cmp_flag_ff <= 1'b0;
    end
  end

  assign ovf_irq_out = ovf_flag_ff & ovf_msk_ff & gie_ff;
  assign cmp_irq_out = cmp_flag_ff & cmp_msk_ff & gie_ff;

  // ---------------------------------------------------------------
  // waveform generator
  // ---------------------------------------------------------------
  always @*
  begin
    nxt_oc = oc_ff;
    if (force_cmp)
      nxt_oc = oc_action(avs_writedata_in[`TCU_COM_LSB +: 2], oc_ff,
        1'b1); // acts like a match; no flag, no reload
    else if (tick & match & ~block_ff & ~wr_cnt)
    begin
      case (waveform_mode)
        WGM_FPWM:
          nxt_oc = (compare_output_action[1]) ?
            compare_output_action[0] : oc_ff;
        WGM_PCPWM:
          nxt_oc = (compare_output_action[1]) ?
            (compare_output_action[0] ^ down_ff) : oc_ff;
        default:
          nxt_oc = oc_action(compare_output_action, oc_ff, 1'b1);
      endcase
    end
    else if (tick & (waveform_mode == WGM_FPWM) & top_out &
      compare_output_action[1])
      nxt_oc = ~compare_output_action[0]; // restart at top
  end

  always @(posedge clk_sys_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
      oc_ff <= 1'b0;
    else
      oc_ff <= nxt_oc;
  end

  assign compare_output_out = oc_ff;
endmodule

/* dv/tcu_chk.sv */
// port checker of the timer unit, bound onto tcu_timer
// assumes one clock, async active-high reset, byte lane 0 for 8-bit regs
`timescale 1ns/1ps
`include "tcu_regs.vh"
module tcu_chk (
  input wire clk_sys_in,
  input wire sys_rst_in,
  input wire [3:0] avs_address_in,
  input wire avs_read_in,
  input wire avs_write_in,
  input wire [31:0] avs_writedata_in,
  input wire [3:0] avs_byteenable_in,
  input wire avs_waitrequest_out,
  input wire [31:0] avs_readdata_out,
  input wire ovf_irq_out,
  input wire cmp_irq_out,
  input wire compare_output_out,
  input wire bottom_out
);
  // ---------------------------------------------------------------
  // shadow of cpu writes
  // ---------------------------------------------------------------
  wire wr_ok = avs_write_in && !avs_waitrequest_out;
  wire rd_ok = avs_read_in && !avs_waitrequest_out;
  wire [7:0] wd = avs_writedata_in[7:0];
  wire be0 = avs_byteenable_in[0];
  wire ctl_wr = wr_ok && be0 && avs_address_in == `TCU_OFS_CTRL;
  wire cnt_wr = wr_ok && be0 && avs_address_in == `TCU_OFS_COUNT;
  wire flg_wr = wr_ok && avs_address_in == `TCU_OFS_FLAG;
  reg [2:0] cs_ff;
  reg [3:0] stop_ff;
  reg om_ff;
  reg cm_ff;
  reg gie_ff;
  // settle time: a tick already in flight may still land after stopping
  wire foc = ctl_wr && wd[`TCU_FOC_BIT] && wd[2:0] == 3'h0 && stop_ff >= 4'h4;
  wire pwm = wd[`TCU_WGM_LSB];
  wire [1:0] act = wd[6:5];
  always @(posedge clk_sys_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      cs_ff <= 3'h0;
      stop_ff <= 4'h0;
      om_ff <= 1'b0;
      cm_ff <= 1'b0;
      gie_ff <= 1'b0;
    end
    else
    begin
      if (ctl_wr)
        cs_ff <= wd[2:0];
      if (cs_ff != 3'h0)
        stop_ff <= 4'h0;
      else if (stop_ff != 4'hf)
        stop_ff <= stop_ff + 4'h1;
      if (flg_wr && avs_byteenable_in[1])
      begin
        om_ff <= avs_writedata_in[`TCU_MSK_OVF_BIT];
        cm_ff <= avs_writedata_in[`TCU_MSK_CMP_BIT];
      end
      if (flg_wr && avs_byteenable_in[2])
        gie_ff <= avs_writedata_in[`TCU_GIE_BIT];
    end
  end
  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (sys_rst_in);
  AST_WAIT_FIRST: assert property ($rose(avs_read_in || avs_write_in)
    |-> avs_waitrequest_out) else $error("waitrequest low on new request");
  AST_WAIT_ONE: assert property ((avs_read_in || avs_write_in) &&
    avs_waitrequest_out |=> !avs_waitrequest_out)
    else $error("request not answered after one wait");
  AST_UNMAPPED: assert property (rd_ok && avs_address_in[1:0] != 2'h0
    |-> avs_readdata_out == 32'h0) else $error("unmapped read not zero");
  AST_FOC_READ: assert property (rd_ok && avs_address_in == 4'h0
    |-> !avs_readdata_out[7]) else $error("force strobe reads one");
  AST_FOC_TGL: assert property (foc && !pwm && act == 2'h1 |=>
    compare_output_out != $past(compare_output_out))
    else $error("forced toggle missing");
  AST_FOC_CLR: assert property (foc && !pwm && act == 2'h2 |=>
    !compare_output_out) else $error("forced clear missing");
  AST_FOC_SET: assert property (foc && !pwm && act == 2'h3 |=>
    compare_output_out) else $error("forced set missing");
  AST_FOC_NOP: assert property (foc && (pwm || act == 2'h0) |=>
    $stable(compare_output_out)) else $error("output moved on idle force");
  // stop_ff lags a restart by one edge, so cs_ff must read zero as well
  AST_STOPPED: assert property (stop_ff >= 4'h4 && cs_ff == 3'h0 &&
    !cnt_wr |=> $stable(bottom_out))
    else $error("counter moved while stopped");
  AST_CMP_IRQ: assert property (cmp_irq_out |-> cm_ff && gie_ff)
    else $error("compare irq without enables");
  AST_OVF_IRQ: assert property (ovf_irq_out |-> om_ff && gie_ff)
    else $error("overflow irq without enables");
  AST_COUNT_WR: assert property (cnt_wr |=>
    bottom_out == ($past(wd) == 8'h00)) else $error("count write lost");
endmodule

bind tcu_timer tcu_chk u_chk (.clk_sys_in(clk_sys_in),
  .sys_rst_in(sys_rst_in), .avs_address_in(avs_address_in),
  .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
  .avs_writedata_in(avs_writedata_in),
  .avs_byteenable_in(avs_byteenable_in),
  .avs_waitrequest_out(avs_waitrequest_out),
  .avs_readdata_out(avs_readdata_out), .ovf_irq_out(ovf_irq_out),
  .cmp_irq_out(cmp_irq_out), .compare_output_out(compare_output_out),
  .bottom_out(bottom_out));

/* dv/timer8_counter_compare_unit_bench.sv */
// self-checking bench of the timer unit
// assumes tcu_timer and the bound checker are compiled before it
`timescale 1ns/1ps
`include "tcu_regs.vh"
module timer8_counter_compare_unit_bench;
  localparam [3:0] a_ctl = `TCU_OFS_CTRL;
  localparam [3:0] a_cnt = `TCU_OFS_COUNT;
  localparam [3:0] a_cmp = `TCU_OFS_CMP;
  localparam [3:0] a_flg = `TCU_OFS_FLAG;
  reg clk_sys_in = 1'b0;
  reg sys_rst_in = 1'b1;
  reg [3:0] adr = 4'h0;
  reg rd = 1'b0;
  reg wr = 1'b0;
  reg [31:0] wdat = 32'h0;
  reg [3:0] be = 4'h0;
  reg ext = 1'b0;
  reg oack = 1'b0;
  reg cack = 1'b0;
  reg [31:0] rs = 32'h0000e614;
  reg [31:0] q;
  integer num_errors = 0;
  integer check_count = 0;
  integer cyc = 0;
  integer i;
  integer n;
  integer m_out = 0;
  wire wt_w;
  wire [31:0] rdat;
  wire oirq, cirq, cout, top, bot;
  tcu_timer uut (
    .clk_sys_in(clk_sys_in),
    .sys_rst_in(sys_rst_in),
    .avs_address_in(adr),
    .avs_read_in(rd),
    .avs_write_in(wr),
    .avs_writedata_in(wdat),
    .avs_byteenable_in(be),
    .avs_waitrequest_out(wt_w),
    .avs_readdata_out(rdat),
    .ext_count_input_in(ext),
    .ovf_irq_ack_in(oack),
    .cmp_irq_ack_in(cack),
    .ovf_irq_out(oirq),
    .cmp_irq_out(cirq),
    .compare_output_out(cout),
    .top_out(top),
    .bottom_out(bot)
  );
  always #2 clk_sys_in = ~clk_sys_in;
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task results;
    begin
      if (num_errors == 0 && check_count > 0)
        $display("ALL TESTS PASSED");
      else
        $display("TESTS FAILED");
      $finish;
    end
  endtask
  always @(posedge clk_sys_in)
  begin
    cyc = cyc + 1;
    if (cyc == 5000)
    begin
      num_errors = num_errors + 1;
      results;
    end
  end
  function [31:0] xs;
    input [31:0] s;
    reg [31:0] t;
    begin
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      xs = t ^ (t << 5);
    end
  endfunction
  task chk;
    input [31:0] s;
    input [31:0] e;
    begin
      check_count = check_count + 1;
      if (s !== e)
      begin
        num_errors = num_errors + 1;
        $display("mismatch at %0t: got %h want %h", $time, s, e);
      end
    end
  endtask
  // waits for the slave, however slow; only the cycle ceiling ends it
  task bus;
    input w;
    input [3:0] a;
    input [31:0] d;
    begin
      adr <= a;
      wdat <= d;
      be <= (a == a_flg) ? 4'h7 : 4'h1;
      wr <= w;
      rd <= !w;
      @(posedge clk_sys_in);
      while (wt_w !== 1'b0)
        @(posedge clk_sys_in);
      q = rdat;
      wr <= 1'b0;
      rd <= 1'b0;
      @(posedge clk_sys_in);
    end
  endtask
  task upto;
    input integer lim;
    begin
      n = 0;
      while (bot !== 1'b1 && n < lim)
      begin
        n = n + 1;
        @(posedge clk_sys_in);
      end
    end
  endtask
  task pulse;
    begin
      ext <= 1'b1;
      repeat (4) @(posedge clk_sys_in);
      ext <= 1'b0;
      repeat (4) @(posedge clk_sys_in);
    end
  endtask
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  initial
  begin
    repeat (4) @(posedge clk_sys_in);
    sys_rst_in <= 1'b0;
    @(posedge clk_sys_in);
    chk({bot, top, cout}, 3'h4);
    for (i = 0; i < 16; i = i + 2)
    begin
      bus(1'b0, i[3:0], 32'h0);
      chk(q, 32'h0);
    end
    for (i = 0; i < 4; i = i + 1)
    begin
      rs = xs(rs);
      bus(1'b1, a_cnt, {24'h0, rs[7:0]});
      bus(1'b1, a_cmp, {24'h0, rs[15:8]});
      bus(1'b0, a_cnt, 32'h0);
      chk(q[7:0], rs[7:0]);
      bus(1'b0, a_cmp, 32'h0);
      chk(q[7:0], rs[15:8]);
      chk(bot, rs[7:0] == 8'h00);
    end
    bus(1'b1, a_cnt, 32'hfc);
    bus(1'b1, a_flg, 32'h3);
    bus(1'b1, a_ctl, 32'h01);
    upto(300);
    chk(bot, 1'b1);
    // write while counting, then overflow flag must read one and clear on writing one
    bus(1'b1, a_cnt, 32'h0);
    bus(1'b1, a_ctl, 32'h0);
    bus(1'b0, a_flg, 32'h0);
    chk(q[0], 1'b1);
    bus(1'b1, a_flg, 32'h1);
    bus(1'b0, a_flg, 32'h0);
    chk(q[0], 1'b0);
    bus(1'b1, a_cnt, 32'h10);
    bus(1'b1, a_cmp, 32'h18);
    bus(1'b1, a_flg, 32'h10203);
    bus(1'b1, a_ctl, 32'h01);
    n = 0;
    while (cirq !== 1'b1 && n < 40)
    begin
      n = n + 1;
      @(posedge clk_sys_in);
    end
    chk({cirq, oirq}, 2'h2);
    bus(1'b1, a_ctl, 32'h0);
    cack <= 1'b1;
    @(posedge clk_sys_in);
    cack <= 1'b0;
    @(posedge clk_sys_in);
    chk(cirq, 1'b0);
    bus(1'b1, a_cmp, 32'h20);
    bus(1'b1, a_cnt, 32'h20);
    bus(1'b1, a_flg, 32'h3);
    bus(1'b1, a_ctl, 32'h01);
    repeat (10) @(posedge clk_sys_in);
    bus(1'b1, a_ctl, 32'h0);
    bus(1'b0, a_flg, 32'h0);
    chk(q[1], 1'b0);
    bus(1'b1, a_cmp, 32'h5);
    bus(1'b1, a_cnt, 32'h0);
    bus(1'b1, a_ctl, 32'h11);
    upto(300);
    n = 0;
    repeat (2)
    begin
      n = n + 1;
      @(posedge clk_sys_in);
    end
    upto(20);
    upto(1);
    n = 0;
    @(posedge clk_sys_in);
    n = 1;
    while (bot !== 1'b1 && n < 20)
    begin
      if (n == 5)
        chk(top, 1'b1);
      n = n + 1;
      @(posedge clk_sys_in);
    end
    chk(n, 6);
    bus(1'b1, a_ctl, 32'h0);
    bus(1'b1, a_cnt, 32'h77);
    bus(1'b1, a_flg, 32'h3);
    for (i = 0; i < 10; i = i + 1)
    begin
      if (i < 8)
        bus(1'b1, a_ctl, {24'h0, 1'b1, i[1:0], i[2], 4'h0});
      else
        bus(1'b1, a_ctl, (i == 8) ? 32'ha8 : 32'hb8);
      if (i < 8 && i[1:0] == 2'h1)
        m_out = !m_out;
      else if (i < 8 && i[1])
        m_out = i[0];
      chk(cout, m_out);
    end
    bus(1'b0, a_cnt, 32'h0);
    chk(q[7:0], 8'h77);
    bus(1'b0, a_flg, 32'h0);
    chk(q[1:0], 2'h0);
    bus(1'b0, a_ctl, 32'h0);
    chk(q[7], 1'b0);
    bus(1'b1, a_ctl, 32'h0);
    bus(1'b1, a_cnt, 32'hfd);
    bus(1'b1, a_ctl, 32'h07);
    repeat (3) pulse;
    chk(bot, 1'b1);
    bus(1'b1, a_ctl, 32'h06);
    pulse;
    bus(1'b0, a_cnt, 32'h0);
    chk(q[7:0], 8'h01);
    bus(1'b1, a_cnt, 32'h0);
    bus(1'b1, a_ctl, 32'h02);
    repeat (80) @(posedge clk_sys_in);
    bus(1'b1, a_ctl, 32'h0);
    bus(1'b0, a_cnt, 32'h0);
    chk(q >= 32'h9 && q <= 32'hc, 1'b1);
    // pwm: cpu writes land in the buffer, active value waits for top
    bus(1'b1, a_ctl, 32'hc0);
    chk(cout, 1'b0);
    bus(1'b1, a_cmp, 32'h40);
    bus(1'b1, a_ctl, 32'h18);
    bus(1'b1, a_cmp, 32'h46);
    bus(1'b0, a_cmp, 32'h0);
    chk(q[7:0], 8'h46);
    bus(1'b1, a_cnt, 32'h45);
    bus(1'b1, a_flg, 32'h3);
    bus(1'b1, a_ctl, 32'h19);
    bus(1'b1, a_ctl, 32'h18);
    bus(1'b0, a_flg, 32'h0);
    chk(q[1], 1'b0);
    bus(1'b1, a_cnt, 32'hfd);
    bus(1'b1, a_ctl, 32'h59);
    bus(1'b1, a_ctl, 32'h0);
    chk(cout, 1'b1);
    bus(1'b0, a_cmp, 32'h0);
    chk(q[7:0], 8'h46);
    results;
  end
endmodule
